//--- src/mdm_pkg.sv
// constants shared by the management master design files
package mdm_pkg;

    // byte register indices on the byte register port
    localparam logic [2:0] IDX_CMD_B1 = 3'h0;
    localparam logic [2:0] IDX_CMD_B2 = 3'h1;
    localparam logic [2:0] IDX_CMD_B3 = 3'h2;
    localparam logic [2:0] IDX_CMD_B4 = 3'h3;
    localparam logic [2:0] IDX_RES_LO = 3'h4;
    localparam logic [2:0] IDX_RES_HI = 3'h5;
    localparam logic [2:0] IDX_RES_B2 = 3'h6;
    localparam logic [2:0] IDX_RES_B3 = 3'h7;

    // command word field positions
    localparam int CMD_START_BIT = 31;
    localparam int CMD_DIR_BIT   = 26;
    localparam int CMD_PHY_LSB   = 21;
    localparam int CMD_REG_LSB   = 16;
    localparam int CMD_DATA_LSB  = 0;

    // reset values
    localparam logic [31:0] CMD_RST = 32'h0000_0000;
    localparam logic [15:0] RES_RST = 16'h0000;

    // frame layout, bit positions counted from the first preamble bit
    localparam logic [5:0]  FRM_START_POS = 6'h20;
    localparam logic [5:0]  FRM_OP_POS    = 6'h22;
    localparam logic [5:0]  FRM_TA_POS    = 6'h2e;
    localparam logic [5:0]  FRM_DATA_POS  = 6'h30;
    localparam logic [5:0]  FRM_LAST_POS  = 6'h3f;
    localparam logic [31:0] FRM_PREAMBLE  = 32'hffff_ffff;
    localparam logic [1:0]  FRM_START     = 2'h1;
    localparam logic [1:0]  FRM_OP_WR     = 2'h1;
    localparam logic [1:0]  FRM_OP_RD     = 2'h2;
    localparam logic [1:0]  FRM_TA_WR     = 2'h2;

    // timing of the sourced management clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int MDC_PERIOD_NS = 800;
    localparam int MDC_HALF_CYC  = MDC_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int DIV_W         = 3;

endpackage

//--- src/mdm_clk_if.sv
// management clock edge events between the clock unit and the frame engine
`timescale 1ns/1ps
interface mdm_clk_if;
    logic run;
    logic ext_mode;
    logic mdc_rise;
    logic mdc_fall;

    // clock unit side
    modport gen (
        input  run,
        input  ext_mode,
        output mdc_rise,
        output mdc_fall
    );

    // frame engine side
    modport eng (
        output run,
        output ext_mode,
        input  mdc_rise,
        input  mdc_fall
    );
endinterface

//--- src/mdm_mdc_gen.sv
// management clock source and edge finder for an external clock
`timescale 1ns/1ps
module mdm_mdc_gen (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // management clock pin
    input  wire logic mdc_i,
    output logic      mdc_o,
    // edge events
    mdm_clk_if.gen    ck
);
    localparam logic [mdm_pkg::DIV_W-1:0] HALF_LAST =
        mdm_pkg::DIV_W'(mdm_pkg::MDC_HALF_CYC - 1);

    logic [2:0]                mdc_sync_r;
    logic                      mdc_lvl_r;
    logic [mdm_pkg::DIV_W-1:0] div_r;
    logic                      ext_rise;
    logic                      ext_fall;
    logic                      int_tog;

    // three stage sampler, a level counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_sync_r <= 3'h0;
            mdc_lvl_r  <= 1'b0;
        end else begin
            mdc_sync_r <= {mdc_sync_r[1:0], mdc_i};
            if (mdc_sync_r[1] == mdc_sync_r[2]) begin
                mdc_lvl_r <= mdc_sync_r[2];
            end
        end
    end

    // edges of the filtered external clock and of the divider
    assign ext_rise = (mdc_sync_r[1] == mdc_sync_r[2]) && mdc_sync_r[2] && !mdc_lvl_r;
    assign ext_fall = (mdc_sync_r[1] == mdc_sync_r[2]) && !mdc_sync_r[2] && mdc_lvl_r;
    assign int_tog  = ck.run && (div_r == HALF_LAST);

    // divider from the system clock, held low between frames and when sourced outside (see R19)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
            mdc_o <= 1'b0;
        end else if (!ck.run || ck.ext_mode) begin
            div_r <= '0;
            mdc_o <= 1'b0;
        end else if (int_tog) begin
            div_r <= '0;
            mdc_o <= !mdc_o;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // one cycle edge events for the selected clock source (see R17)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck.mdc_rise <= 1'b0;
            ck.mdc_fall <= 1'b0;
        end else if (ck.ext_mode) begin
            ck.mdc_rise <= ext_rise;
            ck.mdc_fall <= ext_fall;
        end else begin
            ck.mdc_rise <= int_tog && !mdc_o;
            ck.mdc_fall <= int_tog && mdc_o;
        end
    end
endmodule

//--- src/mdm_master.sv
// phy management master: byte command registers and serial frame engine
//
// Overview of operation
// R1 - command word is 32 bits, built from four byte registers written in order
// R2 - lowest two command bytes give the 16 data bits sent on a write
// R3 - third byte is command bits 23:16, fourth byte is bits 31:24
// R4 - command bits 25:21 give the phy address field of the frame
// R5 - command bits 20:16 give the register address field of the frame
// R6 - command bit 26 set means write, clear means read
// R7 - writing one to bit 31 starts; it reads one until transfer completes
// R8 - up to 32 phys, each with up to 32 registers, are addressable
// R9 - read data is captured into result bits 7:0 and 15:8
// R10 - result bits 30:16 always read as zero
// R11 - result bit 31 flags a failed read; software then discards the data
// R12 - a frame starts with preamble, then start bits zero then one
// R13 - opcode is zero one for write and one zero for read
// R14 - turnaround: master drives one zero on writes, releases first bit on reads
// R15 - on writes the master drives the data line for the whole frame
// R16 - on reads the master releases the line from turnaround; phy drives data
// R17 - management clock pin is an output when sourced, an input otherwise
// R18 - one master serves phys on both ports, chosen only by address
// R19 - sourced clock is divided from system clock; data sampled on rising edge
// R20 - 32 preamble ones, then fields in order, data most significant bit first
// R21 - command writes are ignored while busy; fields latch at transfer start
`timescale 1ns/1ps
module mdm_master (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // byte register port
    input  wire logic [2:0] reg_sel,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // configuration and state
    input  wire logic       mdc_src_sel,
    output logic            xfer_busy,
    // management clock pin
    input  wire logic       mdc_i,
    output logic            mdc_o,
    output logic            mdc_oe,
    // management data pin
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe
);
    mdm_clk_if ck ();

    logic [31:0] cmd_r;
    logic        busy_r;
    logic        rd_op_r;
    logic        pend_r;
    logic [5:0]  bit_cnt_r;
    logic [63:0] tx_r;
    logic [2:0]  mdio_sync_r;
    logic        mdio_lvl_r;
    logic [15:0] rx_r;
    logic        ta_bad_r;
    logic [15:0] res_r;
    logic        err_r;
    logic        start;
    logic        last_rise;
    logic [5:0]  bit_cnt_nxt;
    logic [63:0] frame;

    // register write decode, shared by every command byte and the start
    function automatic logic sel_hit(input logic wr, input logic [2:0] sel,
                                     input logic [2:0] idx);
        sel_hit = wr && (sel == idx);
    endfunction

    // serial frame from a command word, first bit at the top (see R20)
    function automatic logic [63:0] build_frame(input logic [31:0] cmd);
        logic [1:0] op;
        logic [1:0] ta;
        op = cmd[mdm_pkg::CMD_DIR_BIT] ? mdm_pkg::FRM_OP_WR : mdm_pkg::FRM_OP_RD;
        ta = cmd[mdm_pkg::CMD_DIR_BIT] ? mdm_pkg::FRM_TA_WR : 2'h3;
        build_frame = {mdm_pkg::FRM_PREAMBLE, mdm_pkg::FRM_START, op, // see R12 see R13
                       cmd[mdm_pkg::CMD_PHY_LSB +: 5],                // see R4 see R8 see R18
                       cmd[mdm_pkg::CMD_REG_LSB +: 5],                // see R5
                       ta,                                            // see R14
                       cmd[mdm_pkg::CMD_DATA_LSB +: 16]};             // see R2
    endfunction

    // start on a fourth byte write with its top bit set while idle (see R7)
    assign start       = sel_hit(reg_wr, reg_sel, mdm_pkg::IDX_CMD_B4) &&
                         reg_wdata[7] && !busy_r;
    assign frame       = build_frame({reg_wdata, cmd_r[23:0]});       // see R3 see R21
    assign last_rise   = busy_r && ck.mdc_rise && (bit_cnt_r == mdm_pkg::FRM_LAST_POS);
    assign bit_cnt_nxt = bit_cnt_r + 6'h01;
    assign ck.run      = busy_r;

    // clock source and edge finder
    mdm_mdc_gen u_mdc (
        .clk   (clk),
        .rst_n (rst_n),
        .mdc_i (mdc_i),
        .mdc_o (mdc_o),
        .ck    (ck)
    );

    // clock pin direction follows the source select (see R17)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_oe      <= 1'b0;
            ck.ext_mode <= 1'b1;
        end else begin
            mdc_oe      <= mdc_src_sel;
            ck.ext_mode <= !mdc_src_sel;
        end
    end

    // four command bytes, locked while a transfer runs (see R1 see R21)
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cmd
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cmd_r[8*g +: 8] <= mdm_pkg::CMD_RST[8*g +: 8];
                end else if (!busy_r && sel_hit(reg_wr, reg_sel, 3'(g))) begin
                    cmd_r[8*g +: 8] <= reg_wdata;
                end
            end
        end
    endgenerate

    // frame engine: after a rise, step and change data on the next falling edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r    <= 1'b0;
            rd_op_r   <= 1'b0;
            pend_r    <= 1'b0;
            bit_cnt_r <= 6'h00;
            tx_r      <= 64'h0;
            mdio_o    <= 1'b0;
            mdio_oe   <= 1'b0;
        end else if (start) begin
            busy_r    <= 1'b1;
            rd_op_r   <= !reg_wdata[mdm_pkg::CMD_DIR_BIT - 24];  // see R6
            pend_r    <= 1'b0;
            bit_cnt_r <= 6'h00;
            tx_r      <= frame;
            mdio_o    <= frame[63];
            mdio_oe   <= 1'b1;
        end else if (busy_r) begin
            if (ck.mdc_rise) begin
                if (last_rise) begin
                    busy_r  <= 1'b0;                             // see R7
                    mdio_o  <= 1'b0;
                    mdio_oe <= 1'b0;
                end else begin
                    pend_r <= 1'b1;
                end
            end else if (ck.mdc_fall && pend_r) begin
                pend_r    <= 1'b0;
                bit_cnt_r <= bit_cnt_nxt;
                tx_r      <= {tx_r[62:0], 1'b0};
                mdio_o    <= tx_r[62];
                mdio_oe   <= !rd_op_r || (bit_cnt_nxt < mdm_pkg::FRM_TA_POS); // see R15 see R16
            end
        end
    end

    // three stage sampler of the data pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdio_sync_r <= 3'h7;  // line idles high, so no false level after reset
            mdio_lvl_r  <= 1'b1;
        end else begin
            mdio_sync_r <= {mdio_sync_r[1:0], mdio_i};
            if (mdio_sync_r[1] == mdio_sync_r[2]) begin
                mdio_lvl_r <= mdio_sync_r[2];
            end
        end
    end

    // read capture on rising edges: turnaround check and data shift
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_r     <= 16'h0000;
            ta_bad_r <= 1'b0;
        end else if (start) begin
            ta_bad_r <= 1'b0;
        end else if (busy_r && rd_op_r && ck.mdc_rise) begin
            if (bit_cnt_r == mdm_pkg::FRM_TA_POS + 6'h01) begin
                ta_bad_r <= mdio_lvl_r;                          // see R14 see R19
            end
            if (bit_cnt_r >= mdm_pkg::FRM_DATA_POS) begin
                rx_r <= {rx_r[14:0], mdio_lvl_r};                // see R20
            end
        end
    end

    // result word and error flag, updated when a read completes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_r <= mdm_pkg::RES_RST;
            err_r <= 1'b0;
        end else if (last_rise && rd_op_r) begin
            res_r <= {rx_r[14:0], mdio_lvl_r};                   // see R9
            err_r <= ta_bad_r;                                   // see R11
        end
    end

    // registered read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_sel)
                mdm_pkg::IDX_CMD_B1: reg_rdata <= cmd_r[7:0];
                mdm_pkg::IDX_CMD_B2: reg_rdata <= cmd_r[15:8];
                mdm_pkg::IDX_CMD_B3: reg_rdata <= cmd_r[23:16];
                mdm_pkg::IDX_CMD_B4: reg_rdata <= {busy_r, cmd_r[30:24]}; // see R7
                mdm_pkg::IDX_RES_LO: reg_rdata <= res_r[7:0];             // see R9
                mdm_pkg::IDX_RES_HI: reg_rdata <= res_r[15:8];
                mdm_pkg::IDX_RES_B2: reg_rdata <= 8'h00;                  // see R10
                mdm_pkg::IDX_RES_B3: reg_rdata <= {err_r, 7'h00};         // see R11
                default:             reg_rdata <= 8'h00;
            endcase
        end
    end

    // busy state toward the user
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_busy <= 1'b0;
        end else begin
            xfer_busy <= busy_r || start;
        end
    end

    // checks of the frame engine and the registers
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_start_sets_busy: assert property (start |=> busy_r && xfer_busy) // see R7
        else $error("start did not raise busy");
    a_cmd_locked: assert property (busy_r && reg_wr |=> $stable(cmd_r[23:0])) // see R21
        else $error("command changed during transfer");
    a_write_drives: assert property (busy_r && !rd_op_r |-> mdio_oe) // see R15
        else $error("write released the data line");
    a_read_release: assert property (busy_r && rd_op_r && bit_cnt_r >= mdm_pkg::FRM_TA_POS
                                     |-> !mdio_oe) // see R16
        else $error("read drove the line after turnaround");
    a_preamble_ones: assert property (busy_r && bit_cnt_r < mdm_pkg::FRM_START_POS
                                      |-> mdio_o) // see R12
        else $error("preamble bit not one");
    a_start_field: assert property (busy_r && bit_cnt_r == mdm_pkg::FRM_START_POS
                                    && ck.mdc_fall && pend_r |=> mdio_o) // see R12
        else $error("second start bit not one");
    a_opcode_first: assert property (busy_r && bit_cnt_r == mdm_pkg::FRM_OP_POS
                                     |-> mdio_o == rd_op_r) // see R13
        else $error("first opcode bit wrong");
    a_ta_write: assert property (busy_r && !rd_op_r && bit_cnt_r == mdm_pkg::FRM_TA_POS
                                 |-> mdio_o) // see R14
        else $error("write turnaround first bit not one");
    a_err_capture: assert property (last_rise && rd_op_r |=> err_r == $past(ta_bad_r)) // see R11
        else $error("read error flag not captured");
    a_rsvd_zero: assert property (reg_sel == mdm_pkg::IDX_RES_B2 |=> reg_rdata == 8'h00) // see R10
        else $error("reserved result byte not zero");

    // idle line and clock, bit timing, frame fields and register views
    a_idle_release: assert property (!busy_r |-> !mdio_oe) // see R16
        else $error("data line driven while idle");
    a_mdc_idle_low: assert property (!busy_r |=> !mdc_o) // see R19
        else $error("management clock not low while idle");
    a_bit_period: assert property (busy_r && !ck.ext_mode && ck.mdc_rise && !last_rise // see R19
                                   |-> ##8 ck.mdc_rise)
        else $error("sourced clock period wrong");
    a_start_frame: assert property (start // see R12
                                    |=> busy_r && mdio_oe && mdio_o && bit_cnt_r == 6'h00)
        else $error("frame did not open with a driven preamble bit");
    a_start_zero: assert property (busy_r && bit_cnt_r == mdm_pkg::FRM_START_POS // see R12
                                   |-> !mdio_o)
        else $error("first start bit not zero");
    a_op_second: assert property (busy_r && bit_cnt_r == mdm_pkg::FRM_OP_POS + 6'h01 // see R13
                                  |-> mdio_o != rd_op_r)
        else $error("second opcode bit wrong");
    a_ta_wr_zero: assert property (busy_r && !rd_op_r // see R14
                                   && bit_cnt_r == mdm_pkg::FRM_TA_POS + 6'h01 |-> !mdio_o)
        else $error("write turnaround second bit not zero");
    a_cnt_steady: assert property (busy_r && !ck.mdc_fall // see R20
                                   |=> $stable(bit_cnt_r))
        else $error("bit counter moved without a falling edge");
    a_last_clear: assert property (last_rise |=> !busy_r && !mdio_oe) // see R7
        else $error("transfer end did not clear busy and drive");
    a_err_clear: assert property (start |=> !ta_bad_r) // see R11
        else $error("error flag not cleared at transfer start");
    a_res_hold: assert property (!(last_rise && rd_op_r) |=> $stable(res_r)) // see R9
        else $error("result changed outside a read");
    a_rdata_busy: assert property (reg_sel == mdm_pkg::IDX_CMD_B4 // see R7
                                   |=> reg_rdata[7] == $past(busy_r))
        else $error("start bit does not show busy");
    a_rsvd_top: assert property (reg_sel == mdm_pkg::IDX_RES_B3 // see R10
                                 |=> reg_rdata[6:0] == 7'h00)
        else $error("reserved result bits not zero");

    c_write_done: cover property (last_rise && !rd_op_r);
    c_read_ok: cover property (last_rise && rd_op_r && !ta_bad_r);
    c_read_err: cover property (last_rise && rd_op_r && ta_bad_r);
    c_ext_clock: cover property (busy_r && ck.ext_mode && ck.mdc_rise);
    c_locked_write: cover property (busy_r && reg_wr);
endmodule

//--- testbench/mdm_phy_model.sv
// behavioural phy on the shared management bus: records frames and answers reads
`timescale 1ns/1ps
module mdm_phy_model #(
    parameter logic [4:0] PHY_ADDR = 5'h1f
) (
    // bus lines as seen on the wires
    input  wire logic        mdc,
    input  wire logic        mdio,
    input  wire logic        mst_oe,
    // phy drive onto the data line
    output logic             phy_o,
    output logic             phy_oe,
    // last complete frame as sampled
    output logic      [63:0] frame_r,
    output logic      [63:0] oe_r
);
    logic [63:0] bits_r;
    logic [63:0] oes_r;
    logic [15:0] mem_r [32];
    logic [15:0] rd_r;
    logic        resp_r;
    int          pos_r;

    // quiet bus and empty register file at start
    initial begin
        phy_o = 1'b0;
        phy_oe = 1'b0;
        resp_r = 1'b0;
        pos_r = 0;
        foreach (mem_r[i]) mem_r[i] = 16'h0000;
    end

    // sample on each rising edge once the master starts a frame
    always @(posedge mdc) begin
        if (pos_r != 0 || mst_oe) begin
            bits_r = {bits_r[62:0], mdio};
            oes_r = {oes_r[62:0], mst_oe};
            pos_r = pos_r + 1;
            if (pos_r == 46) begin
                resp_r = bits_r[11:10] == 2'h2 && bits_r[9:5] == PHY_ADDR;
                rd_r = mem_r[bits_r[4:0]];
            end
            if (pos_r == 64) begin
                if (bits_r[29:28] == 2'h1 && bits_r[27:23] == PHY_ADDR)
                    mem_r[bits_r[22:18]] = bits_r[15:0];
                frame_r = bits_r;
                oe_r = oes_r;
                resp_r = 1'b0;
                pos_r = 0;
            end
        end
    end

    // drive turnaround zero then data msb first after falling edges, else release
    always @(negedge mdc) begin
        phy_oe = resp_r && pos_r >= 47;
        phy_o = (pos_r == 47) ? 1'b0 : rd_r[4'(63 - pos_r)];
    end
endmodule

//--- testbench/testbench.sv
// self-checking bench: byte register traffic, frames on the wires, both clock sources
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end
module testbench;
    localparam logic [4:0] PHY_HERE = 5'h1f;
    logic        clk, rst_n, reg_wr, mdc_src_sel, xfer_busy, mdc_o, mdc_oe;
    logic        mdio_o, mdio_oe, phy_o, phy_oe, ext_mdc, ext_run, res_err;
    logic [2:0]  reg_sel;
    logic [7:0]  reg_wdata, reg_rdata, rd_v;
    logic [15:0] res_exp;
    logic [63:0] frame_r, oe_r;
    int          fails, n_tests, cycles;
    wire logic   mdc_w = mdc_oe ? mdc_o : ext_mdc;
    wire logic   mdio_w = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1); // pull-up on the line

    mdm_master mdm_master_i (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mdc_src_sel(mdc_src_sel),
        .xfer_busy(xfer_busy), .mdc_i(mdc_w), .mdc_o(mdc_o), .mdc_oe(mdc_oe),
        .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe(mdio_oe));

    mdm_phy_model #(.PHY_ADDR(PHY_HERE)) mdm_phy_model_i (.mdc(mdc_w), .mdio(mdio_w),
        .mst_oe(mdio_oe), .phy_o(phy_o), .phy_oe(phy_oe), .frame_r(frame_r), .oe_r(oe_r));

    // system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // external management clock, runs only within frames, low 500 ns high 300 ns
    initial forever begin
        wait (ext_run);
        #37;
        while (ext_run) begin
            #500 ext_mdc = 1'b1;
            #300 ext_mdc = 1'b0;
        end
    end

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one byte register write, strobe for one edge then an idle edge
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        reg_sel = sel;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // one byte register read, data registered one edge after select
    task automatic rd(input logic [2:0] sel, output logic [7:0] d);
        reg_sel = sel;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask

    // full transfer: command bytes, busy checks, frame on the wire, result bytes
    task automatic xfer(input logic ext, input logic wr_dir, input logic [4:0] phy,
                        input logic [4:0] rg, input logic [15:0] d);
        logic [31:0] cmd;
        logic [63:0] exp_oe;
        logic        hit;
        int          n;
        cmd = {1'b1, 4'h0, wr_dir, phy, rg, d};
        hit = wr_dir || phy == PHY_HERE;
        exp_oe = wr_dir ? 64'hffff_ffff_ffff_ffff : {{46{1'b1}}, 18'h0};
        mdc_src_sel = ~ext;
        wr(mdm_pkg::IDX_CMD_B1, cmd[7:0]);
        wr(mdm_pkg::IDX_CMD_B2, cmd[15:8]);
        wr(mdm_pkg::IDX_CMD_B3, cmd[23:16]);
        wr(mdm_pkg::IDX_CMD_B4, cmd[31:24]);
        ext_run = ext;
        rd(mdm_pkg::IDX_CMD_B4, rd_v);
        `CHK(rd_v, cmd[31:24])
        `CHK(xfer_busy, 1'b1)
        `CHK(mdc_oe, ~ext)
        wr(mdm_pkg::IDX_CMD_B1, ~cmd[7:0]);
        wr(mdm_pkg::IDX_CMD_B4, 8'hff);
        n = 0;
        while (xfer_busy !== 1'b0 && n < 1500) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(n < 1500, 1'b1)
        ext_run = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(xfer_busy, 1'b0)
        `CHK(frame_r, {32'hffff_ffff, 2'h1, wr_dir ? 2'h1 : 2'h2, phy, rg, hit ? 2'h2 : 2'h3, d})
        `CHK(oe_r, exp_oe)
        if (!wr_dir) begin
            res_exp = d;
            res_err = !hit;
        end
        rd(mdm_pkg::IDX_RES_LO, rd_v);
        `CHK(rd_v, res_exp[7:0])
        rd(mdm_pkg::IDX_RES_HI, rd_v);
        `CHK(rd_v, res_exp[15:8])
        rd(mdm_pkg::IDX_RES_B2, rd_v);
        `CHK(rd_v, 8'h00)
        rd(mdm_pkg::IDX_RES_B3, rd_v);
        `CHK(rd_v, {res_err, 7'h00})
        rd(mdm_pkg::IDX_CMD_B1, rd_v);
        `CHK(rd_v, cmd[7:0])
        rd(mdm_pkg::IDX_CMD_B4, rd_v);
        `CHK(rd_v, {1'b0, cmd[30:24]})
        $display("transfer ext %0d write %0d phy %h reg %h done", ext, wr_dir, phy, rg);
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        reg_sel = 3'h0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        mdc_src_sel = 1'b1;
        ext_mdc = 1'b0;
        ext_run = 1'b0;
        res_exp = 16'h0000;
        res_err = 1'b0;
        fails = 0;
        n_tests = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        #1;
        for (int i = 4; i < 8; i++) wr(3'(i), 8'hff);
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), rd_v);
            `CHK(rd_v, 8'h00)
        end
        wr(mdm_pkg::IDX_CMD_B4, 8'h7f);
        rd(mdm_pkg::IDX_CMD_B4, rd_v);
        `CHK(rd_v, 8'h7f)
        `CHK(xfer_busy, 1'b0)
        $display("reset and read-only test done");
        xfer(1'b0, 1'b1, PHY_HERE, 5'h1f, 16'hbeef);
        xfer(1'b0, 1'b0, PHY_HERE, 5'h1f, 16'hbeef);
        xfer(1'b0, 1'b0, 5'h00, 5'h1f, 16'hffff);
        xfer(1'b1, 1'b1, PHY_HERE, 5'h00, 16'h1234);
        xfer(1'b1, 1'b0, PHY_HERE, 5'h00, 16'h1234);
        wrap_up();
    end
endmodule
